// >>> rsc_reset_combiner.sv
// Decided for this implementation: the APB register port and the address map.
`default_nettype none
module rsc_reset_combiner
#(
  parameter bit CFG_MISMATCH_PRESENT = 1'b1
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        BROWN_OUT_RESET,
  input  wire logic        EXTERNAL_CLEAR_PIN_RESET,
  input  wire logic        SOFTWARE_RESET_INSTRUCTION,
  input  wire logic        WATCHDOG_TIMEOUT_RESET,
  input  wire logic        CONFIG_MISMATCH_RESET,
  input  wire logic        TRAP_CONFLICT_RESET,
  input  wire logic        ILLEGAL_OPCODE_RESET,
  input  wire logic        UNINIT_WREG_RESET,
  input  wire logic        SECURITY_RESET,
  input  wire logic        SLEEP_WAKE_EVENT,
  input  wire logic        IDLE_WAKE_EVENT,
  output logic             MASTER_SYSTEM_RESET,
  output logic             SOFT_BROWNOUT_ENABLE,
  output logic             WATCHDOG_SW_ENABLE,
  output logic             REGULATOR_STANDBY_CTRL,
  output logic             FLASH_REGULATOR_CTRL
);
  import rsc_pkg::*;

  // ---------------------------------------------------------------
  // Sources
  // ---------------------------------------------------------------
  logic [15:0]          status_r;
  logic [15:0]          status_nxt;
  logic                 master_r;
  logic [15:0]          set_mask;
  logic [15:0]          wake_mask;
  logic                 any_src;
  logic [15:0]          wr_data;
  logic [15:0]          wr_mask;
  logic [15:0]          written;
  logic [15:0]          ctrl_forced;
  logic [RSC_SRC_N-1:0] src_vec;

  assign src_vec = {SECURITY_RESET, UNINIT_WREG_RESET,
                    ILLEGAL_OPCODE_RESET, TRAP_CONFLICT_RESET,
                    CONFIG_MISMATCH_RESET, WATCHDOG_TIMEOUT_RESET,
                    SOFTWARE_RESET_INSTRUCTION,
                    EXTERNAL_CLEAR_PIN_RESET, BROWN_OUT_RESET};

  rsc_source_combiner #(
    .CFG_MISMATCH_PRESENT (CFG_MISMATCH_PRESENT)
  ) u_comb (
    .src        (src_vec),
    .set_mask   (set_mask),
    .any_active (any_src)
  );

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  rsc_apb_slave u_apb (
    .clk      (CLOCK),
    .rst_n    (RESET_N),
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .paddr    (PADDR),
    .pwdata   (PWDATA),
    .pstrb    (PSTRB),
    .rd_value (status_r),
    .prdata   (PRDATA),
    .pready   (PREADY),
    .pslverr  (PSLVERR),
    .wr_data  (wr_data),
    .wr_mask  (wr_mask)
  );

  // ---------------------------------------------------------------
  // Status update
  // ---------------------------------------------------------------
  always_comb begin
    wake_mask                = 16'h0000;
    wake_mask[RSC_BIT_SLEEP] = SLEEP_WAKE_EVENT;
    wake_mask[RSC_BIT_IDLE]  = IDLE_WAKE_EVENT;
  end

  // Plain storage; flags steer nothing that could reset the chip
  assign written = (status_r & ~wr_mask) | (wr_data & wr_mask);
  // Low-power and watchdog controls return to defaults on any reset
  assign ctrl_forced = any_src
                     ? ((written & ~RSC_CTRL_MASK) | RSC_CTRL_RST)
                     : written;
  // Hardware set wins over a software clear in the same cycle;
  // flags of other causes keep what they held
  assign status_nxt = (ctrl_forced | set_mask | wake_mask)
                    & RSC_IMPL_MASK;

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_r <= RSC_STATUS_POR;
      master_r <= 1'b1;
    end else begin
      status_r <= status_nxt;
      master_r <= any_src;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign MASTER_SYSTEM_RESET    = master_r;
  assign SOFT_BROWNOUT_ENABLE   = status_r[RSC_BIT_SBOR_EN];
  assign WATCHDOG_SW_ENABLE     = status_r[RSC_BIT_WDT_EN];
  assign REGULATOR_STANDBY_CTRL = status_r[RSC_BIT_VREG];
  assign FLASH_REGULATOR_CTRL   = status_r[RSC_BIT_FVREG];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  logic first_r;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  wire any_illegal = ILLEGAL_OPCODE_RESET | UNINIT_WREG_RESET
                   | SECURITY_RESET;
  wire quiet       = ~any_src & ~SLEEP_WAKE_EVENT & ~IDLE_WAKE_EVENT;
  wire sw_write    = |wr_mask;
  wire [15:0] strb_mask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire rd_taken    = PSEL & PENABLE & ~PREADY & ~PWRITE & (PADDR == RSC_ADDR_STATUS);
  wire err_taken   = PSEL & PENABLE & ~PREADY & (PADDR != RSC_ADDR_STATUS);

  sequence s_write_lands;
    sw_write && quiet;
  endsequence

  sequence s_source_pulse;
    any_src ##1 !any_src;
  endsequence

  property p_master_on;
    any_src |=> MASTER_SYSTEM_RESET;
  endproperty
  a_master_on: assert property (p_master_on)
    else $error("master reset missed an active source");

  property p_master_off;
    s_source_pulse |=> !MASTER_SYSTEM_RESET;
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("master reset held after sources went quiet");

  property p_pin_flag;
    EXTERNAL_CLEAR_PIN_RESET |=> status_r[RSC_BIT_EXTR];
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("pin reset flag not set");

  property p_illegal_shared;
    any_illegal && !TRAP_CONFLICT_RESET && !sw_write
      |=> status_r[RSC_BIT_ILLEGAL] && $stable(status_r[RSC_BIT_TRAP]);
  endproperty
  a_illegal_shared: assert property (p_illegal_shared)
    else $error("illegal condition flag wrong");

  property p_wdt_flag;
    WATCHDOG_TIMEOUT_RESET && !SOFTWARE_RESET_INSTRUCTION && !sw_write
      |=> status_r[RSC_BIT_WATCHDOG] && !$changed(status_r[RSC_BIT_SW_RESET]);
  endproperty
  a_wdt_flag: assert property (p_wdt_flag)
    else $error("watchdog flag wrong or instruction flag disturbed");

  property p_por_value;
    first_r |-> status_r == RSC_STATUS_POR;
  endproperty
  a_por_value: assert property (p_por_value)
    else $error("power-on status value wrong");

  property p_sw_write;
    s_write_lands |=> status_r == ((($past(status_r) & ~$past(strb_mask))
                                  | ($past(PWDATA[15:0]) & $past(strb_mask)))
                                  & RSC_IMPL_MASK);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write not stored");

  property p_no_sw_reset;
    s_write_lands |=> !MASTER_SYSTEM_RESET [*2];
  endproperty
  a_no_sw_reset: assert property (p_no_sw_reset)
    else $error("flag write caused a reset");

  property p_trap_bit;
    TRAP_CONFLICT_RESET ##1 (quiet && !sw_write)[*3]
      |-> status_r[RSC_BIT_TRAP];
  endproperty
  a_trap_bit: assert property (p_trap_bit)
    else $error("trap flag lost");

  property p_unimpl_zero;
    status_r[12] == 1'b0 && status_r[10] == 1'b0 && PRDATA[31:16] == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bits read non-zero");

  property p_ctrl_forced;
    any_src |=> (status_r & RSC_CTRL_MASK) == RSC_CTRL_RST;
  endproperty
  a_ctrl_forced: assert property (p_ctrl_forced)
    else $error("control bits survived system reset");

  property p_hold;
    quiet && !sw_write |=> $stable(status_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status changed with no cause");

  property p_ready_one;
    PREADY |=> !PREADY;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("ready stood longer than one cycle");

  property p_err_no_write;
    PREADY && PSLVERR && quiet |=> $stable(status_r);
  endproperty
  a_err_no_write: assert property (p_err_no_write)
    else $error("refused access changed the status");

  property p_read_data;
    rd_taken |=> PREADY && PRDATA == {16'h0000, $past(status_r)};
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data does not match status");

  property p_err_flag;
    err_taken |=> PREADY && PSLVERR && PRDATA == 32'h0000_0000;
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("unmapped access not refused");

  property p_brownout_flag;
    BROWN_OUT_RESET |=> status_r[RSC_BIT_BROWNOUT];
  endproperty
  a_brownout_flag: assert property (p_brownout_flag)
    else $error("brown-out flag not set");

  property p_swreset_flag;
    SOFTWARE_RESET_INSTRUCTION |=> status_r[RSC_BIT_SW_RESET];
  endproperty
  a_swreset_flag: assert property (p_swreset_flag)
    else $error("reset instruction flag not set");

  property p_cfg_flag;
    CONFIG_MISMATCH_RESET && CFG_MISMATCH_PRESENT |=> status_r[RSC_BIT_CFG_MISMATCH];
  endproperty
  a_cfg_flag: assert property (p_cfg_flag)
    else $error("configuration mismatch flag not set");

  property p_trap_set;
    TRAP_CONFLICT_RESET |=> status_r[RSC_BIT_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap flag not set");

  property p_wake_no_reset;
    !any_src && (SLEEP_WAKE_EVENT || IDLE_WAKE_EVENT) |=> !MASTER_SYSTEM_RESET;
  endproperty
  a_wake_no_reset: assert property (p_wake_no_reset)
    else $error("wake event raised the master reset");

  // Non-power-on resets may only clear the control bits
  property p_flags_kept;
    any_src && !sw_write
      |=> (($past(status_r) & ~status_r) & (RSC_IMPL_MASK & ~RSC_CTRL_MASK)) == 16'h0000;
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flag lost across a system reset");
endmodule
`default_nettype wire

// >>> rsc_pkg.sv
`default_nettype none
package rsc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  RSC_ADDR_STATUS = 8'h00;
  localparam logic [15:0] RSC_STATUS_POR  = 16'h0003;
  localparam logic [15:0] RSC_IMPL_MASK   = 16'hebff;
  localparam logic [15:0] RSC_CTRL_MASK   = 16'h0920;
  localparam logic [15:0] RSC_CTRL_RST    = 16'h0000;
  // ---------------------------------------------------------------
  // Field positions of reset_cause_status
  // ---------------------------------------------------------------
  localparam int RSC_BIT_POR       = 0;
  localparam int RSC_BIT_BROWNOUT  = 1;
  localparam int RSC_BIT_IDLE      = 2;
  localparam int RSC_BIT_SLEEP     = 3;
  localparam int RSC_BIT_WATCHDOG  = 4;
  localparam int RSC_BIT_WDT_EN    = 5;
  localparam int RSC_BIT_SW_RESET  = 6;
  localparam int RSC_BIT_EXTR      = 7;
  localparam int RSC_BIT_VREG      = 8;
  localparam int RSC_BIT_CFG_MISMATCH = 9;
  localparam int RSC_BIT_FVREG     = 11;
  localparam int RSC_BIT_SBOR_EN   = 13;
  localparam int RSC_BIT_ILLEGAL   = 14;
  localparam int RSC_BIT_TRAP      = 15;
  localparam int RSC_WIDTH         = 16;
  localparam int RSC_SRC_N         = 9;
endpackage
`default_nettype wire

// >>> rsc_apb_slave.sv
`default_nettype none
module rsc_apb_slave
  import rsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [15:0] rd_value,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] wr_data,
  output logic      [15:0] wr_mask
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  wire         hit    = (paddr == RSC_ADDR_STATUS);
  wire         first  = psel & penable & ~pready_r;
  // A write lands only at the edge where pready is seen high
  wire         wr_en  = psel & penable & pready_r & pwrite & hit;

  assign wr_data = pwdata[15:0];
  assign wr_mask = {{8{pstrb[1] & wr_en}}, {8{pstrb[0] & wr_en}}};
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------
  // One wait state: answer in the second access cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= first;
      if (first) begin
        prdata_r  <= (hit && !pwrite) ? {16'h0000, rd_value} : 32'h0000_0000;
        pslverr_r <= ~hit;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rsc_source_combiner.sv
`default_nettype none
module rsc_source_combiner
  import rsc_pkg::*;
#(
  parameter bit CFG_MISMATCH_PRESENT = 1'b1
) (
  input  wire logic [RSC_SRC_N-1:0] src,
  output logic      [15:0]          set_mask,
  output logic                      any_active
);
  // ---------------------------------------------------------------
  // Source order: brown-out, pin, instruction, watchdog, mismatch,
  // trap, opcode, wreg, security
  // ---------------------------------------------------------------
  wire [RSC_SRC_N-1:0] live = src & {4'hf, CFG_MISMATCH_PRESENT, 4'hf};
  wire                 illegal = |live[8:6];

  assign any_active = |live;
  always_comb begin
    set_mask                  = 16'h0000;
    set_mask[RSC_BIT_BROWNOUT] = live[0];
    set_mask[RSC_BIT_EXTR]    = live[1];
    set_mask[RSC_BIT_SW_RESET] = live[2];
    set_mask[RSC_BIT_WATCHDOG] = live[3];
    set_mask[RSC_BIT_CFG_MISMATCH] = live[4];
    set_mask[RSC_BIT_TRAP]    = live[5];
    // Three illegal-condition causes share one flag
    set_mask[RSC_BIT_ILLEGAL] = illegal;
  end
endmodule
`default_nettype wire

// >>> reset_source_combiner_bench.sv
`default_nettype none
module reset_source_combiner_bench
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] src;
  logic        msr;
  logic        sbor_en;
  logic        wdt_en;
  logic        vreg_ctl;
  logic        fvreg_ctl;
  int          failures;
  int          check_count;
  logic [15:0] exp_st;
  // Status bit set by each entry of src, wake events last
  localparam int SRC_BIT [11] = '{RSC_BIT_BROWNOUT, RSC_BIT_EXTR, RSC_BIT_SW_RESET, RSC_BIT_WATCHDOG,
                                  RSC_BIT_CFG_MISMATCH, RSC_BIT_TRAP, RSC_BIT_ILLEGAL, RSC_BIT_ILLEGAL,
                                  RSC_BIT_ILLEGAL, RSC_BIT_SLEEP, RSC_BIT_IDLE};

  rsc_reset_combiner #(.CFG_MISMATCH_PRESENT(1'b1)) DUT (
    .CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BROWN_OUT_RESET(src[0]), .EXTERNAL_CLEAR_PIN_RESET(src[1]),
    .SOFTWARE_RESET_INSTRUCTION(src[2]), .WATCHDOG_TIMEOUT_RESET(src[3]),
    .CONFIG_MISMATCH_RESET(src[4]), .TRAP_CONFLICT_RESET(src[5]), .ILLEGAL_OPCODE_RESET(src[6]),
    .UNINIT_WREG_RESET(src[7]), .SECURITY_RESET(src[8]), .SLEEP_WAKE_EVENT(src[9]),
    .IDLE_WAKE_EVENT(src[10]), .MASTER_SYSTEM_RESET(msr), .SOFT_BROWNOUT_ENABLE(sbor_en),
    .WATCHDOG_SW_ENABLE(wdt_en), .REGULATOR_STANDBY_CTRL(vreg_ctl), .FLASH_REGULATOR_CTRL(fvreg_ctl)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits an edge first so a release never meets a new setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) failures++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic exp_e);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, s, q, e);
    check({31'h0, e}, {31'h0, exp_e});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, q, e);
    check(q, exp);
    check({31'h0, e}, {31'h0, exp_e});
  endtask

  // One-cycle source pulse; only true reset sources may raise the system reset
  task automatic pulse(input int i);
    @(posedge clock);
    src[i] <= 1'b1;
    @(posedge clock);
    src[i] <= 1'b0;
    #1;
    check({31'h0, msr}, 32'(i < 9));
    @(posedge clock);
    #1;
    check({31'h0, msr}, 32'h0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, src} = '0;
    reset_n = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    check({31'h0, msr}, 32'h1);
    reset_n <= 1'b1;
    rd_chk(RSC_ADDR_STATUS, 32'h0003, 1'b0);
    $display("power-on value done");
    wr(RSC_ADDR_STATUS, 32'hffff_ffff, 4'hf, 1'b0);
    check({31'h0, msr}, 32'h0);
    rd_chk(RSC_ADDR_STATUS, 32'h0000_ebff, 1'b0);
    check({28'h0, sbor_en, fvreg_ctl, vreg_ctl, wdt_en}, 32'hf);
    wr(RSC_ADDR_STATUS, 32'h0, 4'hf, 1'b0);
    wr(RSC_ADDR_STATUS, 32'h0000_ffff, 4'h2, 1'b0);
    rd_chk(RSC_ADDR_STATUS, 32'h0000_eb00, 1'b0);
    wr(RSC_ADDR_STATUS, 32'h0, 4'hf, 1'b0);
    rd_chk(RSC_ADDR_STATUS, 32'h0, 1'b0);
    $display("software access done");
    // Flags accumulate, so each read also shows earlier causes kept
    exp_st = 16'h0;
    for (int i = 0; i < 11; i++) begin
      pulse(i);
      exp_st = exp_st | (16'h1 << SRC_BIT[i]);
      rd_chk(RSC_ADDR_STATUS, {16'h0, exp_st}, 1'b0);
    end
    $display("reset sources done");
    wr(RSC_ADDR_STATUS, 32'h0000_ffff, 4'hf, 1'b0);
    pulse(3);
    rd_chk(RSC_ADDR_STATUS, 32'h0000_e2df, 1'b0);
    check({28'h0, sbor_en, fvreg_ctl, vreg_ctl, wdt_en}, 32'h8);
    $display("control bits done");
    wr(8'h04, 32'h0, 4'hf, 1'b1);
    rd_chk(8'h04, 32'h0, 1'b1);
    rd_chk(RSC_ADDR_STATUS, 32'h0000_e2df, 1'b0);
    $display("unmapped access done");
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    #1;
    check({31'h0, msr}, 32'h1);
    check({28'h0, sbor_en, fvreg_ctl, vreg_ctl, wdt_en}, 32'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    rd_chk(RSC_ADDR_STATUS, 32'h0003, 1'b0);
    $display("second power-on done");
    end_of_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
`default_nettype wire
